// *** verilog/voiceband_dac_regs.vh ***
// Constants for the voiceband playback path: control fields, timing and filter scaling.
// How it works
// - One 16-bit sample accepted per 8 kHz frame.
// - Missing sample: previous sample is replayed.
// - Order: high-pass, interpolator, then modulator.
// - Modulator emits one bit per 1 MHz tick.
// - Second-order loop pushes noise out of band.
// - Control bit 2 skips the high-pass stage.
// - High-pass is 4th-order IIR at 8 kHz.
// - First interpolator raises 8 to 40 kHz.
// - Low-pass is 10th-order IIR at 40 kHz.
// - Sinc4 filter smooths the 1 MHz stream.
// - Combined filters keep voiceband ripple small.
// - Control bits 7 to 9 select gain.
// - Serial words are 16 bits, MSB first.
// - Bit clock is master clock divided by 5.
// - Chip select low floats outputs, ignores inputs.
// - Powerdown: clock runs, sync low, data held.
// - Device drives clock, data out, out sync.
// - Word starts one bit after input sync.
// - Reset clears the control word to zero.
`ifndef VOICEBAND_DAC_REGS_VH
`define VOICEBAND_DAC_REGS_VH
// =============================================================
// Control word
`define CTRL_RESET      16'h0000
`define CTRL_HPF_BYP    2
`define CTRL_ANA_PWR    4
`define CTRL_DIG_PWR    5
`define CTRL_GAIN_B0    7
`define CTRL_GAIN_B1    8
`define CTRL_GAIN_B2    9
`define CTRL_WR_FLAG    15
// =============================================================
// Serial port timing
`define WORD_BITS       16
`define SCLK_DIV        3'h5
`define SCLK_FALL       3'h2
`define SCLK_LAST       3'h4
// =============================================================
// Sample rates
`define CLK_KHZ         40000
`define MOD_KHZ         1000
`define TICK_CYC        (`CLK_KHZ / `MOD_KHZ)
`define HOLD_TICKS      25
`define INTERP_RATIO    5
// =============================================================
// Filter arithmetic
`define COEF_FRAC       14
`define COEF_PASS       80'h4000_0000_0000_0000_0000
`define CIC_SHIFT       14
`endif

// *** verilog/biquad_section.v ***
// One second-order IIR section in direct form I with saturating output.
`timescale 1ns/1ps
`default_nettype none
`include "voiceband_dac_regs.vh"
module biquad_section #(
  parameter [79:0] COEF = `COEF_PASS
) (
  // Clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // Sample stream
  input  wire               en_i,
  input  wire signed [15:0] x_i,
  output reg  signed [15:0] y_o
);

  wire signed [15:0] cb0 = COEF[79:64];
  wire signed [15:0] cb1 = COEF[63:48];
  wire signed [15:0] cb2 = COEF[47:32];
  wire signed [15:0] ca1 = COEF[31:16];
  wire signed [15:0] ca2 = COEF[15:0];

  reg  signed [15:0] x1_q;
  reg  signed [15:0] x2_q;
  reg  signed [15:0] y2_q;
  wire signed [39:0] acc;
  wire signed [39:0] scaled;
  wire               ovf;
  wire signed [15:0] y_d;

  assign acc = cb0 * x_i + cb1 * x1_q + cb2 * x2_q - ca1 * y_o - ca2 * y2_q;
  assign scaled = acc >>> `COEF_FRAC;
  // Feedback must saturate rather than wrap, or the section can oscillate.
  assign ovf = ~((&scaled[39:15]) | ~(|scaled[39:15]));
  assign y_d = ovf ? (scaled[39] ? 16'h8000 : 16'h7FFF) : scaled[15:0];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      x1_q <= 16'h0000;
      x2_q <= 16'h0000;
      y2_q <= 16'h0000;
      y_o  <= 16'h0000;
    end
    else if (en_i)
    begin
      x1_q <= x_i;
      x2_q <= x1_q;
      y2_q <= y_o;
      y_o  <= y_d;
    end
  end

endmodule // biquad_section
`default_nettype wire

// *** verilog/voiceband_dac_sample_path.v ***
// Playback path: serial port, filter chain, sinc4 interpolator and sigma-delta modulator.
`timescale 1ns/1ps
`default_nettype none
`include "voiceband_dac_regs.vh"
module voiceband_dac_sample_path #(
  parameter [159:0] HPF_COEF = {2{`COEF_PASS}},
  parameter [399:0] LPF_COEF = {5{`COEF_PASS}}
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Serial port inputs from the host
  input  wire        cs_i,
  input  wire        ser_data_in_i,
  input  wire        in_frame_sync_i,
  input  wire        data_or_ctrl_sel_i,
  // Serial port outputs to the host
  output reg         sclk_o,
  output reg         sclk_oe_n_o,
  output reg         ser_data_out_o,
  output reg         ser_data_out_oe_n_o,
  output reg         out_frame_sync_o,
  output reg         out_frame_sync_oe_n_o,
  // Word to transmit each frame
  input  wire [15:0] adc_word_i,
  // Control word fields
  output wire        play_hpf_bypass_o,
  output wire        out_gain_sel_b0_o,
  output wire        out_gain_sel_b1_o,
  output wire        out_gain_sel_b2_o,
  output wire        digital_powerup_o,
  output wire        analog_powerup_o,
  // Modulator bit stream
  output reg         sd_bit_o
);

  localparam RX_IDLE = 1'b0;
  localparam RX_WORD = 1'b1;
  localparam TX_IDLE = 2'h0;
  localparam TX_SYNC = 2'h1;
  localparam TX_WORD = 2'h2;

  // =============================================================
  // Pin synchronisers
  reg cs_s1_q;
  reg cs_s2_q;
  reg sdi_s1_q;
  reg sdi_s2_q;
  reg fs_s1_q;
  reg fs_s2_q;
  reg dc_s1_q;
  reg dc_s2_q;

  always @(posedge clk_i)
  begin
    cs_s1_q  <= cs_i;
    cs_s2_q  <= cs_s1_q;
    sdi_s1_q <= ser_data_in_i;
    sdi_s2_q <= sdi_s1_q;
    fs_s1_q  <= in_frame_sync_i;
    fs_s2_q  <= fs_s1_q;
    dc_s1_q  <= data_or_ctrl_sel_i;
    dc_s2_q  <= dc_s1_q;
  end

  // Enables follow chip select even in reset, so reset never floats the pins.
  always @(posedge clk_i)
  begin
    sclk_oe_n_o           <= ~cs_s2_q;
    ser_data_out_oe_n_o   <= ~cs_s2_q;
    out_frame_sync_oe_n_o <= ~cs_s2_q;
  end

  // =============================================================
  // Bit clock divider
  reg  [2:0] div_q;
  wire [2:0] div_d;
  wire       bit_ev;

  assign div_d  = (div_q == `SCLK_DIV - 3'h1) ? 3'h0 : div_q + 3'h1;
  assign bit_ev = (div_q == `SCLK_LAST);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Parking in the last low phase makes the first bit clock after reset a full one.
      div_q  <= `SCLK_LAST;
      sclk_o <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      sclk_o <= (div_d < `SCLK_FALL);
    end
  end

  // =============================================================
  // Control word and playback sample
  reg  [15:0] ctrl_q;
  reg  [15:0] sample_q;
  reg         rx_done_q;
  reg         rx_is_data_q;
  reg  [15:0] rx_word_q;
  wire        powered;

  assign play_hpf_bypass_o = ctrl_q[`CTRL_HPF_BYP];
  assign out_gain_sel_b0_o = ctrl_q[`CTRL_GAIN_B0];
  assign out_gain_sel_b1_o = ctrl_q[`CTRL_GAIN_B1];
  assign out_gain_sel_b2_o = ctrl_q[`CTRL_GAIN_B2];
  assign digital_powerup_o = ctrl_q[`CTRL_DIG_PWR];
  assign analog_powerup_o  = ctrl_q[`CTRL_ANA_PWR];
  assign powered = ctrl_q[`CTRL_DIG_PWR] & ctrl_q[`CTRL_ANA_PWR];

  // The sample register is only overwritten by a new word, so a frame
  // without one replays the previous value.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= `CTRL_RESET;
      sample_q <= 16'h0000;
    end
    else if (rx_done_q)
    begin
      if (rx_is_data_q)
      begin
        sample_q <= rx_word_q;
      end
      else if (!rx_word_q[`CTRL_WR_FLAG])
      begin
        ctrl_q <= rx_word_q;
      end
    end
  end

  // =============================================================
  // Serial receiver
  reg        rx_state_q;
  reg  [3:0] rx_cnt_q;
  reg [15:0] rx_sh_q;
  reg        rx_dc_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_state_q   <= RX_IDLE;
      rx_cnt_q     <= 4'h0;
      rx_sh_q      <= 16'h0000;
      rx_dc_q      <= 1'b0;
      rx_done_q    <= 1'b0;
      rx_is_data_q <= 1'b0;
      rx_word_q    <= 16'h0000;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (!cs_s2_q)
      begin
        rx_state_q <= RX_IDLE;
      end
      else if (bit_ev)
      begin
        case (rx_state_q)
          RX_IDLE:
          begin
            if (fs_s2_q)
            begin
              rx_state_q <= RX_WORD;
              rx_cnt_q   <= 4'h0;
              rx_dc_q    <= dc_s2_q;
            end
          end
          RX_WORD:
          begin
            rx_sh_q  <= {rx_sh_q[14:0], sdi_s2_q};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'hF)
            begin
              rx_done_q    <= 1'b1;
              rx_is_data_q <= rx_dc_q;
              rx_word_q    <= {rx_sh_q[14:0], sdi_s2_q};
              // A sync seen early is honoured only in the last bit slot.
              rx_state_q   <= fs_s2_q ? RX_WORD : RX_IDLE;
              rx_cnt_q     <= 4'h0;
              rx_dc_q      <= dc_s2_q;
            end
          end
          default:
          begin
            rx_state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // =============================================================
  // Rate ticks: 1 MHz, 40 kHz and 8 kHz
  reg  [5:0] tick_cnt_q;
  reg  [4:0] hold_cnt_q;
  reg  [2:0] ph_cnt_q;
  reg        t1m_q;
  reg        t40k_q;
  reg        t8k_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_q <= 6'h00;
      hold_cnt_q <= 5'h00;
      ph_cnt_q   <= 3'h0;
      t1m_q      <= 1'b0;
      t40k_q     <= 1'b0;
      t8k_q      <= 1'b0;
    end
    else
    begin
      t1m_q  <= (tick_cnt_q == `TICK_CYC - 1);
      t40k_q <= 1'b0;
      t8k_q  <= 1'b0;
      tick_cnt_q <= (tick_cnt_q == `TICK_CYC - 1) ? 6'h00 : tick_cnt_q + 6'h01;
      if (t1m_q)
      begin
        hold_cnt_q <= (hold_cnt_q == `HOLD_TICKS - 1) ? 5'h00 : hold_cnt_q + 5'h01;
        if (hold_cnt_q == `HOLD_TICKS - 1)
        begin
          t40k_q   <= 1'b1;
          ph_cnt_q <= (ph_cnt_q == `INTERP_RATIO - 1) ? 3'h0 : ph_cnt_q + 3'h1;
          t8k_q    <= (ph_cnt_q == `INTERP_RATIO - 1);
        end
      end
    end
  end

  // =============================================================
  // High-pass and low-pass IIR cascades
  wire signed [15:0] hp_s [0:2];
  wire signed [15:0] lp_s [0:5];
  wire signed [15:0] hp_out;

  assign hp_s[0] = sample_q;
  // The 8 kHz value is held across five 40 kHz ticks into the low-pass.
  assign hp_out  = ctrl_q[`CTRL_HPF_BYP] ? sample_q : hp_s[2];
  assign lp_s[0] = hp_out;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_hpf
      biquad_section #(
        .COEF (HPF_COEF[(g*80)+79:g*80])
      ) u_hpf (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (t8k_q),
        .x_i   (hp_s[g]),
        .y_o   (hp_s[g+1])
      );
    end
    for (g = 0; g < 5; g = g + 1)
    begin : g_lpf
      biquad_section #(
        .COEF (LPF_COEF[(g*80)+79:g*80])
      ) u_lpf (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (t40k_q),
        .x_i   (lp_s[g]),
        .y_o   (lp_s[g+1])
      );
    end
  endgenerate

  // =============================================================
  // Sinc4 interpolator: three combs at 40 kHz, a 25-tick hold, three integrators.
  // The hold is itself one comb and integrator pair, so a fourth comb would null DC.
  reg  signed [39:0] comb_q [0:2];
  reg  signed [39:0] dly_q  [0:2];
  reg  signed [39:0] integ_q [0:2];
  wire signed [39:0] comb_in [0:2];
  wire signed [39:0] integ_in [0:2];
  wire signed [39:0] cic_sh;
  wire               cic_ovf;
  wire signed [15:0] cic_out;

  assign comb_in[0] = {{24{lp_s[5][15]}}, lp_s[5]};
  assign integ_in[0] = comb_q[2];

  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_comb
      if (g > 0)
      begin : g_link
        assign comb_in[g] = comb_q[g-1];
      end
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          comb_q[g] <= 40'h00_0000_0000;
          dly_q[g]  <= 40'h00_0000_0000;
        end
        else if (t40k_q)
        begin
          comb_q[g] <= comb_in[g] - dly_q[g];
          dly_q[g]  <= comb_in[g];
        end
      end
    end
    for (g = 0; g < 3; g = g + 1)
    begin : g_integ
      if (g > 0)
      begin : g_link
        assign integ_in[g] = integ_q[g-1];
      end
      // The last comb output stays put between 40 kHz ticks, which is the hold.
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          integ_q[g] <= 40'h00_0000_0000;
        end
        else if (t1m_q)
        begin
          integ_q[g] <= integ_q[g] + integ_in[g];
        end
      end
    end
  endgenerate

  assign cic_sh  = integ_q[2] >>> `CIC_SHIFT;
  assign cic_ovf = ~((&cic_sh[39:15]) | ~(|cic_sh[39:15]));
  assign cic_out = cic_ovf ? (cic_sh[39] ? 16'h8000 : 16'h7FFF) : cic_sh[15:0];

  // =============================================================
  // Second-order sigma-delta modulator
  reg  signed [23:0] sd1_q;
  reg  signed [23:0] sd2_q;
  wire signed [23:0] sd_x;
  wire signed [23:0] sd_fb;
  wire signed [23:0] sd1_d;
  wire signed [23:0] sd2_d;

  assign sd_x  = {{8{cic_out[15]}}, cic_out};
  assign sd_fb = sd_bit_o ? 24'h00_7FFF : 24'hFF_8000;
  // The bit is taken from the new state and the second stage feeds back twice,
  // otherwise the loop has poles outside the unit circle.
  assign sd1_d = sd1_q + sd_x - sd_fb;
  assign sd2_d = sd2_q + sd1_q - {sd_fb[22:0], 1'b0};

  // Two integrators in the loop give a second-order high-pass noise shape.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sd1_q    <= 24'h00_0000;
      sd2_q    <= 24'h00_0000;
      sd_bit_o <= 1'b0;
    end
    else if (t1m_q)
    begin
      sd1_q    <= sd1_d;
      sd2_q    <= sd2_d;
      sd_bit_o <= ~sd2_d[23];
    end
  end

  // =============================================================
  // Serial transmitter
  reg        tx_req_q;
  reg  [1:0] tx_state_q;
  reg  [3:0] tx_cnt_q;
  reg [15:0] tx_sh_q;
  wire       tx_take;

  assign tx_take = bit_ev & cs_s2_q & powered & (tx_state_q == TX_IDLE);

  // A frame tick in the same cycle as a take still leaves a request pending.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_req_q <= 1'b0;
    end
    else
    begin
      tx_req_q <= t8k_q | (tx_req_q & ~(tx_take & tx_req_q));
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state_q       <= TX_IDLE;
      tx_cnt_q         <= 4'h0;
      tx_sh_q          <= 16'h0000;
      ser_data_out_o   <= 1'b0;
      out_frame_sync_o <= 1'b0;
    end
    else if (!cs_s2_q || !powered)
    begin
      tx_state_q       <= TX_IDLE;
      out_frame_sync_o <= 1'b0;
    end
    else if (bit_ev)
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_req_q)
          begin
            tx_sh_q          <= adc_word_i;
            out_frame_sync_o <= 1'b1;
            tx_state_q       <= TX_SYNC;
          end
        end
        TX_SYNC:
        begin
          out_frame_sync_o <= 1'b0;
          ser_data_out_o   <= tx_sh_q[15];
          tx_sh_q          <= {tx_sh_q[14:0], 1'b0};
          tx_cnt_q         <= 4'h0;
          tx_state_q       <= TX_WORD;
        end
        TX_WORD:
        begin
          if (tx_cnt_q == 4'hF)
          begin
            tx_state_q <= TX_IDLE;
          end
          else
          begin
            ser_data_out_o <= tx_sh_q[15];
            tx_sh_q        <= {tx_sh_q[14:0], 1'b0};
            tx_cnt_q       <= tx_cnt_q + 4'h1;
          end
        end
        default:
        begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

endmodule // voiceband_dac_sample_path
`default_nettype wire

// *** tb/vdac_checker.sv ***
// Concurrent checks on the ports of the playback path.
`timescale 1ns/1ps
`default_nettype none
module vdac_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial port pins
  input wire logic cs_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_n_o,
  input wire logic ser_data_out_o,
  input wire logic ser_data_out_oe_n_o,
  input wire logic out_frame_sync_o,
  input wire logic out_frame_sync_oe_n_o,
  // Control fields and bit stream
  input wire logic play_hpf_bypass_o,
  input wire logic out_gain_sel_b0_o,
  input wire logic out_gain_sel_b1_o,
  input wire logic out_gain_sel_b2_o,
  input wire logic digital_powerup_o,
  input wire logic analog_powerup_o,
  input wire logic sd_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ============================================================
  // Sequences
  sequence s_bit_clock;
    sclk_o [*2] ##1 !sclk_o [*3];
  endsequence
  sequence s_sync_pulse;
    out_frame_sync_o [*5] ##1 !out_frame_sync_o;
  endsequence
  // ============================================================
  // Assertions
  a_sclk_div_five: assert property ($rose(sclk_o) |-> s_bit_clock ##1 sclk_o)
    else $error("bit clock period is not five cycles");
  a_sync_one_bit: assert property ($rose(out_frame_sync_o) |-> s_sync_pulse)
    else $error("output sync width wrong");
  a_sync_needs_power: assert property ($rose(out_frame_sync_o) |->
    $rose(sclk_o) && digital_powerup_o && analog_powerup_o)
    else $error("output sync without power or off clock");
  a_data_on_rise: assert property ($changed(ser_data_out_o) |-> $rose(sclk_o))
    else $error("serial data changed off the bit clock rise");
  a_powerdown_hold: assert property (!digital_powerup_o [*2] |->
    $stable(ser_data_out_o) && !out_frame_sync_o)
    else $error("powerdown did not hold the data line");
  a_enables_equal: assert property (sclk_oe_n_o == ser_data_out_oe_n_o &&
    sclk_oe_n_o == out_frame_sync_oe_n_o)
    else $error("output enables differ");
  a_cs_float: assert property ($fell(cs_i) |-> ##[1:4] sclk_oe_n_o)
    else $error("outputs not floated after chip select low");
  a_cs_drive: assert property ($rose(cs_i) |-> ##[1:4] !sclk_oe_n_o)
    else $error("outputs not driven after chip select high");
  a_reset_pins_low: assert property (disable iff (1'b0) rst_i |=>
    !sclk_o && !ser_data_out_o && !out_frame_sync_o)
    else $error("pins not low in reset");
  a_reset_ctrl_zero: assert property (disable iff (1'b0) rst_i |=> !play_hpf_bypass_o &&
    !out_gain_sel_b0_o && !out_gain_sel_b1_o && !out_gain_sel_b2_o &&
    !digital_powerup_o && !analog_powerup_o && !sd_bit_o)
    else $error("control not cleared in reset");
  a_sd_tick_rate: assert property ($changed(sd_bit_o) |=> $stable(sd_bit_o) [*8])
    else $error("modulator bit changed too early");
endmodule // vdac_checker
bind voiceband_dac_sample_path vdac_checker i_vdac_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i), .sclk_o(sclk_o),
  .sclk_oe_n_o(sclk_oe_n_o), .ser_data_out_o(ser_data_out_o),
  .ser_data_out_oe_n_o(ser_data_out_oe_n_o), .out_frame_sync_o(out_frame_sync_o),
  .out_frame_sync_oe_n_o(out_frame_sync_oe_n_o), .play_hpf_bypass_o(play_hpf_bypass_o),
  .out_gain_sel_b0_o(out_gain_sel_b0_o), .out_gain_sel_b1_o(out_gain_sel_b1_o),
  .out_gain_sel_b2_o(out_gain_sel_b2_o), .digital_powerup_o(digital_powerup_o),
  .analog_powerup_o(analog_powerup_o), .sd_bit_o(sd_bit_o));
`default_nettype wire

// *** tb/host_port_model.sv ***
// Host serial port model that writes words into the device.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // Bit clock from the device
  input  wire logic sclk_i,
  // Lines driven by the host
  output var  logic sdi_o,
  output var  logic fs_o,
  output var  logic sel_o
);
  initial
  begin
    sdi_o = 1'b0;
    fs_o  = 1'b0;
    sel_o = 1'b0;
  end
  // Sync for one bit clock, then bits launched after each rise; line inverted after.
  task send(input logic [15:0] w, input logic data_sel);
    integer i;
    begin
      @(posedge sclk_i);
      #2;
      fs_o  = 1'b1;
      sel_o = data_sel;
      for (i = 15; i >= 0; i = i - 1)
      begin
        @(posedge sclk_i);
        #2;
        fs_o  = 1'b0;
        sdi_o = w[i];
      end
      @(posedge sclk_i);
      #2;
      sdi_o = ~sdi_o;
    end
  endtask
endmodule // host_port_model
`default_nettype wire

// *** tb/voiceband_dac_sample_path_bench.sv ***
// Self-checking bench for the playback path.
`timescale 1ns/1ps
`default_nettype none
module voiceband_dac_sample_path_bench;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        cs_i       = 1'b1;
  logic [15:0] adc_word_i = 16'hA5C3;
  logic [15:0] w;
  logic [3:0]  k;
  wire         ser_data_in, fsi, sel, sclk, sclk_oen, ser_data_out, sdo_oen, fso, fso_oen;
  wire         byp, g0, g1, g2, dpw, apw, sdb;
  integer      fails       = 0;
  integer      checks_done = 0;
  integer      cycles      = 0;
  integer      i, n, m;
  always #12.5 clk_i = ~clk_i;
  voiceband_dac_sample_path i_voiceband_dac_sample_path (
    .clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i), .ser_data_in_i(ser_data_in),
    .in_frame_sync_i(fsi), .data_or_ctrl_sel_i(sel), .sclk_o(sclk),
    .sclk_oe_n_o(sclk_oen), .ser_data_out_o(ser_data_out), .ser_data_out_oe_n_o(sdo_oen),
    .out_frame_sync_o(fso), .out_frame_sync_oe_n_o(fso_oen), .adc_word_i(adc_word_i),
    .play_hpf_bypass_o(byp), .out_gain_sel_b0_o(g0), .out_gain_sel_b1_o(g1),
    .out_gain_sel_b2_o(g2), .digital_powerup_o(dpw), .analog_powerup_o(apw),
    .sd_bit_o(sdb));
  host_port_model i_host_port_model (.sclk_i(sclk), .sdi_o(ser_data_in), .fs_o(fsi), .sel_o(sel));
  // ============================================================
  // Tasks
  task cyc(input integer c);
    begin
      repeat (c) @(posedge clk_i);
      #2;
    end
  endtask
  task miss(input logic [15:0] got, input logic [15:0] exp);
    begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_word(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) miss(got, exp);
    end
  endtask
  task check_count(input integer got, input integer lo, input integer hi);
    begin
      checks_done = checks_done + 1;
      if (got < lo || got > hi) miss(got[15:0], lo[15:0]);
    end
  endtask
  task check_ctrl(input logic [15:0] exp);
    check_word({6'h00, g2, g1, g0, 1'b0, dpw, apw, 1'b0, byp, 2'b00}, exp);
  endtask
  task ctrl_write(input logic [15:0] v);
    begin
      i_host_port_model.send(v, 1'b0);
      cyc(10);
    end
  endtask
  task rx_word(output logic [15:0] r);
    begin
      // Let a sync that is already up pass, so the word is caught from its start.
      while (fso === 1'b1)
        cyc(1);
      n = 0;
      while (fso !== 1'b1 && n < 6000)
      begin
        cyc(1);
        n = n + 1;
      end
      check_word({15'h0000, fso}, 16'h0001);
      @(negedge sclk);
      for (i = 15; i >= 0; i = i - 1)
      begin
        @(negedge sclk);
        #1;
        r[i] = ser_data_out;
      end
      cyc(1);
    end
  endtask
  // Counts ones of the modulator over a number of 1 MHz ticks.
  task count_ones(input integer ticks, output integer c);
    begin
      c = 0;
      repeat (ticks)
      begin
        cyc(40);
        c = c + (sdb === 1'b1);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ============================================================
  // Tests
  initial
  begin
    cyc(3);
    check_word({13'h0000, sclk, ser_data_out, fso}, 16'h0000);
    check_word({15'h0000, sclk_oen}, 16'h0000);
    check_ctrl(16'h0000);
    cyc(1);
    rst_i = 1'b0;
    $display("test reset done");
    for (k = 4'h0; k < 4'h8; k = k + 4'h1)
    begin
      w = {6'h00, k[2:0], 3'b011, 1'b0, k[0], 2'b00};
      ctrl_write(w);
      check_ctrl(w);
    end
    ctrl_write(16'h8000);
    check_ctrl(16'h03B4);
    $display("test control done");
    rx_word(w);
    check_word(w, 16'hA5C3);
    adc_word_i = 16'h5A3C;
    rx_word(w);
    check_word(w, 16'h5A3C);
    $display("test transmit done");
    // Half scale through a unity chain at gain 0.954 gives a ones density near 0.738.
    // The chain settles within about twelve 40 kHz periods of a new sample.
    i_host_port_model.send(16'h4000, 1'b1);
    cyc(14000);
    check_ctrl(16'h03B4);
    count_ones(250, n);
    check_count(n, 175, 195);
    i_host_port_model.send(16'hC000, 1'b1);
    cyc(14000);
    count_ones(250, n);
    check_count(n, 55, 75);
    $display("test playback done");
    cs_i = 1'b0;
    cyc(5);
    check_word({13'h0000, sclk_oen, sdo_oen, fso_oen}, 16'h0007);
    ctrl_write(16'h0000);
    check_ctrl(16'h03B4);
    cs_i = 1'b1;
    cyc(5);
    check_word({15'h0000, sclk_oen}, 16'h0000);
    $display("test chip select done");
    ctrl_write(16'h0000);
    check_ctrl(16'h0000);
    n = 0;
    m = 0;
    repeat (6000)
    begin
      cyc(1);
      n = n + (fso === 1'b1);
      m = m + (sclk === 1'b1);
    end
    check_count(n, 0, 0);
    check_count(m, 2400, 2400);
    $display("test powerdown done");
    ctrl_write(16'h03B4);
    rst_i = 1'b1;
    cyc(4);
    check_ctrl(16'h0000);
    rst_i = 1'b0;
    cyc(2);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // voiceband_dac_sample_path_bench
`default_nettype wire
